// File: icp_pkg.sv
// constants and field layout of the indexed correction table port
package icp_pkg;
  localparam logic [7:0]  REG_TARGET    = 8'h03;
  localparam logic [7:0]  REG_ADDR_HI   = 8'h04;
  localparam logic [7:0]  REG_ADDR_LO   = 8'h05;
  localparam logic [7:0]  REG_DATA      = 8'h06;
  localparam int          TGT_W         = 4;
  localparam int          BIT_BLOCK     = 0;
  localparam int          BIT_COL_LO    = 1;
  localparam int          BIT_DIR       = 5;
  localparam int          ADDR_W        = 13;
  localparam int          HI_W          = 5;
  localparam int          COL_W         = 2;
  localparam int          GAMMA_AW      = 10;
  localparam int          OFS6_LSB      = 2;
  localparam logic [12:0] GAMMA_LAST    = 13'h03ff;
  localparam logic [12:0] COEF_LAST_300 = 13'h0aa9;
  localparam logic [12:0] COEF_LAST_600 = 13'h1554;
  localparam logic [3:0]  TARGET_RST    = 4'h0;
  localparam logic [12:0] ADDR_RST      = 13'h0000;
  localparam logic [7:0]  SEL_RST       = 8'h00;
  localparam logic [7:0]  UNMAPPED_RD   = 8'h00;
endpackage : icp_pkg

// File: icp_table_ram.sv
// single-port table memory with registered read, read-before-write
`timescale 1ns/1ns
module icp_table_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic          clk_en,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // contents carry no reset; software must load tables before use
  always_ff @(posedge sys_clk)
  begin
    if (clk_en)
    begin
      rdata <= mem[addr];
      if (we)
      begin
        mem[addr] <= wdata;
      end
    end
  end
endmodule : icp_table_ram

// File: icp_coef_codec.sv
// splits a stored coefficient word into offset and gain fields
`timescale 1ns/1ns
module icp_coef_codec (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        split_6_10,
  input  wire logic [15:0] word,
  output logic      [7:0]  offset,
  output logic      [9:0]  gain
);
  typedef struct packed {
    logic [7:0] offset;
    logic [9:0] gain;
  } icp_codec_t;

  icp_codec_t s;
  icp_codec_t next_s;

  // first byte sits in word 15:8, second byte in word 7:0
  always_comb
  begin
    next_s = s;
    if (split_6_10)
    begin
      next_s.offset = {2'h0, word[15:8+icp_pkg::OFS6_LSB]};
      next_s.gain   = word[9:0];
    end
    else
    begin
      next_s.offset = word[15:8];
      next_s.gain   = {2'h0, word[7:0]};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      s <= '0;
    else if (clk_en)
      s <= next_s;
  end

  assign offset = s.offset;
  assign gain   = s.gain;
endmodule : icp_coef_codec

// File: icp_table_port.sv
// indexed access port to the gamma tables and offset/gain coefficient store
`timescale 1ns/1ns
module icp_table_port (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        cfg_addr_we,
  input  wire logic        cfg_data_we,
  input  wire logic        cfg_data_re,
  input  wire logic [7:0]  cfg_wdata,
  output logic      [7:0]  cfg_rdata,
  output logic             cfg_busy,
  input  wire logic        one_channel_a,
  input  wire logic [1:0]  one_channel_colour,
  input  wire logic        split_6_10,
  input  wire logic        sensor_600dpi,
  output logic      [12:0] table_addr,
  output logic      [7:0]  coef_offset,
  output logic      [9:0]  coef_gain
);
  typedef struct packed {
    logic [7:0]  cfg_sel;
    logic [3:0]  target;
    logic        dir;
    logic [12:0] addr;
    logic        phase;
    logic [7:0]  first;
    logic [15:0] pf_word;
    logic        pf_valid;
    logic        pf_busy;
    logic [7:0]  rdata;
  } icp_state_t;

  icp_state_t s;
  icp_state_t next_s;

  logic        blk_coef;
  logic [1:0]  colour;
  logic [12:0] last;
  logic        g_we;
  logic        c_we;
  logic [7:0]  g_rdata;
  logic [15:0] c_rdata;
  logic        rd_ok;
  logic        sel_data;

  // step the table address, wrapping to zero past the block's last entry
  function automatic logic [12:0] step_addr(input logic [12:0] a,
                                            input logic [12:0] lim);
    if (a >= lim)
      return icp_pkg::ADDR_RST;
    else
      return a + 13'h0001;
  endfunction : step_addr

  // block and colour decode of the target register
  assign blk_coef = s.target[icp_pkg::BIT_BLOCK];
  // code 11 lands in a spare plane so it never disturbs a real colour
  assign colour = one_channel_a ? one_channel_colour
                                : s.target[icp_pkg::BIT_COL_LO +: icp_pkg::COL_W];

  // wrap point follows the block and the sensor resolution
  assign last = !blk_coef      ? icp_pkg::GAMMA_LAST :
                sensor_600dpi  ? icp_pkg::COEF_LAST_600 :
                                 icp_pkg::COEF_LAST_300;

  assign sel_data = (s.cfg_sel == icp_pkg::REG_DATA);
  // a window read is only taken once the prefetched word is in hand
  assign rd_ok    = cfg_data_re && !cfg_addr_we && !cfg_data_we && sel_data
                    && s.dir && s.pf_valid;
  assign cfg_busy = sel_data && s.dir && !s.pf_valid;

  // coefficient address 0 is the first valid pixel; the pixel side adds
  // its start offset, so no offset is kept here
  icp_table_ram #(
    .AW (icp_pkg::COL_W + icp_pkg::GAMMA_AW),
    .DW (8)
  ) u_gamma_ram (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .we      (g_we),
    .addr    ({colour, s.addr[icp_pkg::GAMMA_AW-1:0]}),
    .wdata   (cfg_wdata),
    .rdata   (g_rdata)
  );

  icp_table_ram #(
    .AW (icp_pkg::COL_W + icp_pkg::ADDR_W),
    .DW (16)
  ) u_coef_ram (
    .sys_clk (sys_clk),
    .clk_en  (clk_en),
    .we      (c_we),
    .addr    ({colour, s.addr}),
    .wdata   ({s.first, cfg_wdata}),
    .rdata   (c_rdata)
  );

  // next state: address latch, register writes, window traffic, prefetch
  always_comb
  begin
    next_s = s;
    g_we   = 1'b0;
    c_we   = 1'b0;
    if (cfg_addr_we)
    begin
      next_s.cfg_sel = cfg_wdata;
    end
    else if (cfg_data_we)
    begin
      case (s.cfg_sel)
        icp_pkg::REG_TARGET:
        begin
          next_s.target   = cfg_wdata[icp_pkg::TGT_W-1:0];
          next_s.pf_valid = 1'b0;
          next_s.pf_busy  = 1'b0;
        end
        icp_pkg::REG_ADDR_HI:
        begin
          next_s.addr[12:8] = cfg_wdata[icp_pkg::HI_W-1:0];
          next_s.dir        = cfg_wdata[icp_pkg::BIT_DIR];
          next_s.phase      = 1'b0;
          next_s.pf_valid   = 1'b0;
          next_s.pf_busy    = 1'b0;
        end
        icp_pkg::REG_ADDR_LO:
        begin
          next_s.addr[7:0] = cfg_wdata;
          next_s.phase     = 1'b0;
          next_s.pf_valid  = 1'b0;
          next_s.pf_busy   = 1'b0;
        end
        icp_pkg::REG_DATA:
        begin
          // any write makes the held prefetch stale
          next_s.pf_valid = 1'b0;
          next_s.pf_busy  = 1'b0;
          if (!blk_coef)
          begin
            g_we        = 1'b1;
            next_s.addr = step_addr(s.addr, last);
          end
          else if (!s.phase)
          begin
            next_s.first = cfg_wdata;
            next_s.phase = 1'b1;
          end
          else
          begin
            c_we         = 1'b1;
            next_s.phase = 1'b0;
            next_s.addr  = step_addr(s.addr, last);
          end
        end
        default:
        begin
          next_s.pf_busy = s.pf_busy;
        end
      endcase
    end
    else if (cfg_data_re)
    begin
      case (s.cfg_sel)
        icp_pkg::REG_TARGET:
          next_s.rdata = {4'h0, s.target};
        icp_pkg::REG_ADDR_HI:
          next_s.rdata = {2'h0, s.dir, s.addr[12:8]};
        icp_pkg::REG_ADDR_LO:
          next_s.rdata = s.addr[7:0];
        icp_pkg::REG_DATA:
        begin
          if (rd_ok)
          begin
            if (!blk_coef)
            begin
              next_s.rdata    = s.pf_word[7:0];
              next_s.addr     = step_addr(s.addr, last);
              next_s.pf_valid = 1'b0;
            end
            else if (!s.phase)
            begin
              next_s.rdata = s.pf_word[15:8];
              next_s.phase = 1'b1;
            end
            else
            begin
              next_s.rdata    = s.pf_word[7:0];
              next_s.phase    = 1'b0;
              next_s.addr     = step_addr(s.addr, last);
              next_s.pf_valid = 1'b0;
            end
          end
          else if (!s.dir)
          begin
            // reading with the write direction set returns zero and holds
            next_s.rdata = icp_pkg::UNMAPPED_RD;
          end
        end
        default:
          next_s.rdata = icp_pkg::UNMAPPED_RD;
      endcase
    end
    else if (s.pf_busy)
    begin
      // ram answer arrives one cycle after the issue
      next_s.pf_word  = blk_coef ? c_rdata : {8'h00, g_rdata};
      next_s.pf_valid = 1'b1;
      next_s.pf_busy  = 1'b0;
    end
    else if (s.dir && !s.pf_valid)
    begin
      // the ram reads s.addr this cycle; mark the fetch in flight
      next_s.pf_busy = 1'b1;
    end
  end

  // whole state is frozen while the clock enable is low
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      s          <= '0;
      s.cfg_sel  <= icp_pkg::SEL_RST;
      s.target   <= icp_pkg::TARGET_RST;
      s.addr     <= icp_pkg::ADDR_RST;
    end
    else if (clk_en)
    begin
      s <= next_s;
    end
  end

  icp_coef_codec u_codec (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .split_6_10 (split_6_10),
    .word       (s.pf_word),
    .offset     (coef_offset),
    .gain       (coef_gain)
  );

  assign cfg_rdata  = s.rdata;
  assign table_addr = s.addr;

  // checks on the register protocol and the address walk
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr(logic [7:0] r);
    clk_en && !cfg_addr_we && cfg_data_we && s.cfg_sel == r;
  endsequence

  sequence s_quiet;
    clk_en && !cfg_addr_we && !cfg_data_we && !cfg_data_re;
  endsequence

  sequence s_need_fetch;
    s_quiet and (s.dir && !s.pf_valid && !s.pf_busy);
  endsequence

  property p_target_load;
    s_wr(icp_pkg::REG_TARGET) |=> s.target == $past(cfg_wdata[3:0]);
  endproperty
  a_target_load: assert property (p_target_load)
    else $error("target register did not load");

  property p_colour_src;
    one_channel_a |-> colour == one_channel_colour;
  endproperty
  a_colour_src: assert property (p_colour_src)
    else $error("single channel colour not used");

  property p_hi_load;
    s_wr(icp_pkg::REG_ADDR_HI) |=> s.addr[12:8] == $past(cfg_wdata[4:0])
      && s.dir == $past(cfg_wdata[5]) && !s.phase && !s.pf_valid;
  endproperty
  a_hi_load: assert property (p_hi_load)
    else $error("high address or direction not loaded");

  property p_lo_phase;
    s_wr(icp_pkg::REG_ADDR_LO) |=> s.addr[7:0] == $past(cfg_wdata) && !s.phase;
  endproperty
  a_lo_phase: assert property (p_lo_phase)
    else $error("low address write did not restart the byte pair");

  property p_prefetch;
    s_need_fetch ##1 s_quiet |=> s.pf_valid;
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("prefetch not ready two cycles after issue");

  property p_gamma_step;
    s_wr(icp_pkg::REG_DATA) and (!blk_coef && s.addr < icp_pkg::GAMMA_LAST)
      |=> s.addr == $past(s.addr) + 13'h0001;
  endproperty
  a_gamma_step: assert property (p_gamma_step)
    else $error("gamma address did not advance by one");

  property p_gamma_wrap;
    s_wr(icp_pkg::REG_DATA) and (!blk_coef && s.addr == icp_pkg::GAMMA_LAST)
      |=> s.addr == icp_pkg::ADDR_RST;
  endproperty
  a_gamma_wrap: assert property (p_gamma_wrap)
    else $error("gamma address did not wrap after 1023");

  property p_coef_hold;
    s_wr(icp_pkg::REG_DATA) and (blk_coef && !s.phase)
      |=> s.phase && $stable(s.addr);
  endproperty
  a_coef_hold: assert property (p_coef_hold)
    else $error("coefficient address moved on the first byte");

  property p_coef_wrap;
    s_wr(icp_pkg::REG_DATA) and (blk_coef && s.phase && s.addr == last)
      |=> s.addr == icp_pkg::ADDR_RST && !s.phase;
  endproperty
  a_coef_wrap: assert property (p_coef_wrap)
    else $error("coefficient address did not wrap at its limit");

  property p_read_byte;
    clk_en && rd_ok && !blk_coef |=> cfg_rdata == $past(s.pf_word[7:0]);
  endproperty
  a_read_byte: assert property (p_read_byte)
    else $error("window read returned the wrong gamma byte");

  // fields trail the prefetched word by one cycle, so compare with its past value
  property p_split;
    clk_en && split_6_10
      |=> coef_gain == $past(s.pf_word[9:0])
      && coef_offset == {2'h0, $past(s.pf_word[15:10])};
  endproperty
  a_split: assert property (p_split)
    else $error("6/10 offset or gain field wrong");

  property p_split_8_8;
    clk_en && !split_6_10
      |=> coef_offset == $past(s.pf_word[15:8])
      && coef_gain == {2'h0, $past(s.pf_word[7:0])};
  endproperty
  a_split_8_8: assert property (p_split_8_8)
    else $error("8/8 offset or gain field wrong");

  property p_coef_step;
    s_wr(icp_pkg::REG_DATA) and (blk_coef && s.phase && s.addr < last)
      |=> s.addr == $past(s.addr) + 13'h0001 && !s.phase;
  endproperty
  a_coef_step: assert property (p_coef_step)
    else $error("coefficient address did not advance after the second byte");

  // a read that uses up the prefetch must raise busy until the next fetch lands
  property p_read_busy;
    clk_en && rd_ok && (!blk_coef || s.phase) |=> cfg_busy;
  endproperty
  a_read_busy: assert property (p_read_busy)
    else $error("busy did not rise after a window read");
endmodule : icp_table_port

// File: icp_host_model.sv
// host model: two-step configuration access on the strobe bus
`timescale 1ns/1ns
module icp_host_model (
  input  wire logic       sys_clk,
  input  wire logic       cfg_busy,
  input  wire logic [7:0] cfg_rdata,
  output logic            cfg_addr_we,
  output logic            cfg_data_we,
  output logic            cfg_data_re,
  output logic      [7:0] cfg_wdata
);
  // quiet bus from time zero
  initial
  begin
    cfg_addr_we = 1'b0;
    cfg_data_we = 1'b0;
    cfg_data_re = 1'b0;
    cfg_wdata   = 8'h00;
  end

  // one strobe between falling edges; released data shows the inverse so it is never reused
  task automatic strobe(input logic [1:0] k, input logic [7:0] d);
    @(negedge sys_clk);
    cfg_wdata   = d;
    cfg_addr_we = (k == 2'h0);
    cfg_data_we = (k == 2'h1);
    cfg_data_re = (k == 2'h2);
    @(negedge sys_clk);
    cfg_addr_we = 1'b0;
    cfg_data_we = 1'b0;
    cfg_data_re = 1'b0;
    cfg_wdata   = ~d;
  endtask : strobe

  // address once, then any number of data accesses
  task automatic set_addr(input logic [7:0] a);
    strobe(2'h0, a);
  endtask : set_addr

  // table traffic only issued while the scanner is idle
  task automatic wr_data(input logic [7:0] d);
    strobe(2'h1, d);
  endtask : wr_data

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    set_addr(a);
    wr_data(d);
  endtask : wr_reg

  // a read while the prefetch is pending would be dropped, so wait, but not forever
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (2) @(negedge sys_clk);
    while (cfg_busy !== 1'b0 && n < 64)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_ready

  // answer is registered and stands until the next read
  task automatic rd_data(output logic [7:0] d);
    wait_ready();
    strobe(2'h2, 8'h00);
    @(negedge sys_clk);
    d = cfg_rdata;
  endtask : rd_data
endmodule : icp_host_model

// File: testbench.sv
// self-checking bench for the indexed correction table port
`timescale 1ns/1ns
module testbench;
  logic        sys_clk;
  logic        sys_rst;
  logic        clk_en;
  logic        cfg_addr_we;
  logic        cfg_data_we;
  logic        cfg_data_re;
  logic [7:0]  cfg_wdata;
  logic [7:0]  cfg_rdata;
  logic        cfg_busy;
  logic        one_channel_a;
  logic [1:0]  one_channel_colour;
  logic        split_6_10;
  logic        sensor_600dpi;
  logic [12:0] table_addr;
  logic [7:0]  coef_offset;
  logic [9:0]  coef_gain;
  int          mismatches;
  int          compares;
  int          cycles;
  int          seed;
  int          gm [int];
  int          cm [int];
  logic [3:0]  mtgt;
  int          maddr;
  logic        mdir;
  logic        mph;
  logic [7:0]  mfirst;
  logic [7:0]  d;
  logic [3:0]  t;
  int          s;
  int          st;
  int          w;

  icp_table_port icp_table_port_i (
    .sys_clk, .sys_rst, .clk_en, .cfg_addr_we, .cfg_data_we, .cfg_data_re, .cfg_wdata,
    .cfg_rdata, .cfg_busy, .one_channel_a, .one_channel_colour, .split_6_10,
    .sensor_600dpi, .table_addr, .coef_offset, .coef_gain
  );
  icp_host_model icp_host_model_i (
    .sys_clk, .cfg_busy, .cfg_rdata, .cfg_addr_we, .cfg_data_we, .cfg_data_re, .cfg_wdata
  );

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard, far above the under one thousand cycles the tests need
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // reference plane index and counter step
  function automatic int key();
    logic [1:0] c;
    c = one_channel_a ? one_channel_colour : mtgt[2:1];
    return int'(c) * 8192 + maddr;
  endfunction : key

  function automatic void step();
    int lim;
    lim = !mtgt[0] ? 1023 : (sensor_600dpi ? 5460 : 2729);
    maddr = (maddr >= lim) ? 0 : maddr + 1;
  endfunction : step

  task automatic cmp(input logic [17:0] g, input logic [17:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    cmp({10'h000, g}, {10'h000, e});
  endtask : chk_byte

  task automatic chk_addr(input logic [12:0] g, input int e);
    cmp({5'h00, g}, {5'h00, e[12:0]});
  endtask : chk_addr

  task automatic chk_coef(input logic [17:0] e);
    cmp({coef_offset, coef_gain}, e);
  endtask : chk_coef

  // target, start address and direction; address rewrites follow every target change
  task automatic setup(input logic [3:0] tg, input int a, input logic dir);
    logic [12:0] a13;
    a13 = a[12:0];
    icp_host_model_i.wr_reg(8'h03, {4'h0, tg});
    icp_host_model_i.wr_reg(8'h04, {2'h0, dir, a13[12:8]});
    icp_host_model_i.wr_reg(8'h05, a13[7:0]);
    icp_host_model_i.set_addr(8'h06);
    mtgt = tg;
    maddr = a;
    mdir = dir;
    mph = 1'b0;
  endtask : setup

  // gamma bytes step at once; coefficient words store {first, second}
  task automatic put(input logic [7:0] b);
    icp_host_model_i.wr_data(b);
    if (!mtgt[0])
    begin
      gm[key()] = b;
      step();
    end
    else if (!mph)
    begin
      mfirst = b;
      mph = 1'b1;
    end
    else
    begin
      cm[key()] = {mfirst, b};
      mph = 1'b0;
      step();
    end
    @(negedge sys_clk);
    chk_addr(table_addr, maddr);
  endtask : put

  task automatic get();
    logic [7:0] e;
    logic       eb;
    icp_host_model_i.rd_data(d);
    e = 8'h00;
    eb = 1'b0;
    if (mdir && !mtgt[0])
    begin
      e = 8'(gm[key()]);
      eb = 1'b1;
      step();
    end
    else if (mdir)
    begin
      w = cm[key()];
      e = mph ? w[7:0] : w[15:8];
      eb = mph;
      if (mph)
        step();
      mph = ~mph;
    end
    // a read that consumed the prefetch leaves busy up while the refetch runs
    chk_byte({7'h00, cfg_busy}, {7'h00, eb});
    chk_byte(d, e);
    chk_addr(table_addr, maddr);
  endtask : get

  initial
  begin
    seed = 43631;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    one_channel_a = 1'b0;
    one_channel_colour = 2'h0;
    split_6_10 = 1'b0;
    sensor_600dpi = 1'b0;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    // registers clear after reset; an unmapped place reads 00 and ignores writes
    chk_addr(table_addr, 0);
    for (s = 3; s < 6; s++)
    begin
      icp_host_model_i.set_addr(8'(s));
      icp_host_model_i.rd_data(d);
      chk_byte(d, 8'h00);
    end
    icp_host_model_i.wr_reg(8'h20, 8'h5a);
    icp_host_model_i.rd_data(d);
    chk_byte(d, 8'h00);
    $display("test reset done");
    // every colour's gamma plane, across the 1023 wrap
    for (s = 0; s < 3; s++)
    begin
      t = 4'(s * 2);
      setup(t, 1021, 1'b0);
      repeat (4) put(8'($random(seed)));
      setup(t, 1021, 1'b1);
      repeat (4) get();
    end
    $display("test gamma done");
    // both splits and both sensors, reloaded each time, odd byte then restart
    for (s = 0; s < 4; s++)
    begin
      split_6_10 = s[0];
      sensor_600dpi = s[1];
      st = s[1] ? 5459 : 2728;
      t = 4'((s % 3) * 2 + 1);
      setup(t, st, 1'b0);
      put(8'($random(seed)));
      setup(t, st, 1'b0);
      repeat (6) put(8'($random(seed)));
      setup(t, st, 1'b1);
      icp_host_model_i.wait_ready();
      repeat (2) @(negedge sys_clk);
      w = cm[key()];
      chk_coef(s[0] ? {2'h0, w[15:10], w[9:0]} : {w[15:8], 2'h0, w[7:0]});
      repeat (6) get();
    end
    $display("test coefficients done");
    // frozen clock enable drops a strobe; window read in write direction yields 00
    setup(4'h0, 100, 1'b0);
    @(negedge sys_clk);
    clk_en = 1'b0;
    icp_host_model_i.wr_data(8'ha5);
    clk_en = 1'b1;
    chk_addr(table_addr, maddr);
    get();
    // single-channel mode takes the colour from its own input
    one_channel_a = 1'b1;
    one_channel_colour = 2'h2;
    setup(4'h0, 5, 1'b0);
    repeat (2) put(8'($random(seed)));
    one_channel_a = 1'b0;
    setup(4'h4, 5, 1'b1);
    repeat (2) get();
    icp_host_model_i.set_addr(8'h04);
    icp_host_model_i.rd_data(d);
    chk_byte(d, 8'h20);
    icp_host_model_i.set_addr(8'h05);
    icp_host_model_i.rd_data(d);
    chk_byte(d, 8'h07);
    $display("test modes done");
    report_and_stop();
  end
endmodule : testbench
